// ---- asr_params.svh ----
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// Register byte offsets
`define ASR_OFF_PIN0 8'h00
`define ASR_OFF_PIN1 8'h04
`define ASR_OFF_PIN2 8'h08
`define ASR_OFF_PIN3 8'h0C
`define ASR_OFF_PIN4 8'h10
`define ASR_OFF_MISC_A 8'h14
`define ASR_OFF_MISC_B 8'h18
`define ASR_OFF_SYS_CONTROL 8'h1C
`define ASR_OFF_STATUS 8'h20

// Field layout
`define ASR_PIN_FIELD_W 7
`define ASR_PIN_FIELDS_PER_REG 4
`define ASR_MISC_FIELD_W 5
`define ASR_MISC_INV4_BIT 30
`define ASR_MISC_INV5_BIT 31
`define ASR_SYS_CONTROL_FLAGS_BIT 20
`define ASR_STATUS_IRQ_LSB 20

// Reset values: every select parks on its constant-low source
`define ASR_RST_PIN 32'h0A14_2850
`define ASR_RST_MISC 32'h3DEF_7BDE
`define ASR_RST_SYS_CONTROL 32'h0000_0000

`endif

// ---- asr_pkg.sv ----
package asr_pkg;

  localparam int ASR_NUM_PINS = 20;
  localparam int ASR_NUM_MISC = 6;
  localparam int ASR_NUM_IRQ = 4;
  localparam int ASR_NUM_PIN_REGS = 5;

  // Pin assignment source codes (0x00..0x51 of the seven-bit encoding)
  localparam logic [6:0] PC_MISC_B_FIRST = 7'h00;
  localparam logic [6:0] PC_MISC_B_LAST = 7'h03;
  localparam logic [6:0] PC_SER_CLK_BASE = 7'h20;
  localparam logic [6:0] PC_SER_CLK_FIRST = 7'h21;
  localparam logic [6:0] PC_SER_CLK_LAST = 7'h25;
  localparam logic [6:0] PC_SER_FS_FIRST = 7'h26;
  localparam logic [6:0] PC_SER_FS_LAST = 7'h2B;
  localparam logic [6:0] PC_TIMER_FIRST = 7'h2C;
  localparam logic [6:0] PC_TIMER_LAST = 7'h2E;
  localparam logic [6:0] PC_FLAG10 = 7'h2F;
  localparam logic [6:0] PC_ACQ_STROBE = 7'h30;
  localparam logic [6:0] PC_FLAG11_FIRST = 7'h34;
  localparam logic [6:0] PC_FLAG11_LAST = 7'h37;
  localparam logic [6:0] PC_PREC_CLK_A = 7'h38;
  localparam logic [6:0] PC_PREC_CLK_B = 7'h39;
  localparam logic [6:0] PC_PREC_FS_A = 7'h3A;
  localparam logic [6:0] PC_PREC_FS_B = 7'h3B;
  localparam logic [6:0] PC_FLAG15 = 7'h3C;
  localparam logic [6:0] PC_RATE_CONV_FIRST = 7'h3D;
  localparam logic [6:0] PC_RATE_CONV_LAST = 7'h40;
  localparam logic [6:0] PC_RX_DATA = 7'h41;
  localparam logic [6:0] PC_RX_FS = 7'h42;
  localparam logic [6:0] PC_RX_CLK = 7'h43;
  localparam logic [6:0] PC_RX_TDM_CLK = 7'h44;
  localparam logic [6:0] PC_TX_DATA = 7'h45;
  localparam logic [6:0] PC_SPI_MISO = 7'h46;
  localparam logic [6:0] PC_SPI_MOSI = 7'h47;
  localparam logic [6:0] PC_SPI_CLK = 7'h48;
  localparam logic [6:0] PC_SPI_SS_FIRST = 7'h49;
  localparam logic [6:0] PC_SPI_SS_LAST = 7'h4C;
  localparam logic [6:0] PC_PLL_FB = 7'h4D;
  localparam logic [6:0] PC_PLL_REF = 7'h4E;
  localparam logic [6:0] PC_LOW = 7'h50;
  localparam logic [6:0] PC_HIGH = 7'h51;

  // Miscellaneous routing source codes
  localparam logic [4:0] MC_PIN_LAST = 5'h13;
  localparam logic [4:0] MC_TIMER_FIRST = 5'h14;
  localparam logic [4:0] MC_TIMER_LAST = 5'h16;
  localparam logic [4:0] MC_ACQ_STROBE = 5'h19;
  localparam logic [4:0] MC_PREC_CLK_A = 5'h1A;
  localparam logic [4:0] MC_PREC_FS_A = 5'h1B;
  localparam logic [4:0] MC_PREC_CLK_B = 5'h1C;
  localparam logic [4:0] MC_PREC_FS_B = 5'h1D;
  localparam logic [4:0] MC_LOW = 5'h1E;
  localparam logic [4:0] MC_HIGH = 5'h1F;

  // On-chip peripheral outputs offered as routing sources
  typedef struct packed {
    logic [5:0] serialPortClk;
    logic [5:0] serialPortFs;
    logic [2:0] timerOut;
    logic [15:0] gpFlagOut;
    logic acquisitionPortStrobe;
    logic [1:0] precisionClock;
    logic [1:0] precisionFrameSync;
    logic [3:0] rateConverterData;
    logic audioReceiverData;
    logic audioReceiverFs;
    logic audioReceiverClock;
    logic audioReceiverTdmClock;
    logic audioTransmitterData;
    logic secondarySpiMiso;
    logic secondarySpiMosi;
    logic secondarySpiClock;
    logic [3:0] secondarySpiSlaveSelect;
    logic pllFeedbackTap;
    logic pllReferenceTap;
  } asr_src_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } asr_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } asr_ahb_rsp_t;

  typedef struct packed {
    logic [ASR_NUM_PIN_REGS-1:0][31:0] pinSel;
    logic [31:0] miscRouteA;
    logic [31:0] miscRouteB;
    logic [31:0] systemControl;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdData;
    logic [ASR_NUM_IRQ-1:0] irqS1;
    logic [ASR_NUM_IRQ-1:0] irqS2;
    logic [ASR_NUM_IRQ-1:0] irqS3;
    logic [ASR_NUM_IRQ-1:0] irqFlag;
    logic [ASR_NUM_PINS-1:0] pinBufIn;
    logic [ASR_NUM_MISC-1:0] miscAIn;
    logic [ASR_NUM_MISC-1:0] miscBIn;
    logic [15:0] parallelPinOut;
  } asr_state_t;

endpackage

// ---- audio_signal_route_mux.sv ----
`timescale 1ns/1ps
`include "asr_params.svh"

// Operation
// - Codes 0x21..0x25 route serial port 1..5 clock to the pin buffer.
// - Codes 0x26..0x2B route serial port 0..5 frame sync, ascending.
// - Codes 0x2C..0x2E route timer 0..2 outputs.
// - Flag 10 at 0x2F, flags 11..14 at 0x34..0x37, flag 15 at 0x3C.
// - Code 0x30 routes acquisition port strobe; 0x31..0x33 reserved.
// - 0x38/0x39 precision clocks A/B; 0x3A/0x3B precision frame syncs A/B.
// - Codes 0x3D..0x40 route rate converter 0..3 data.
// - 0x41..0x44 receiver data, fs, clock, TDM clock; 0x45 transmitter data.
// - 0x46..0x48 secondary SPI MISO, MOSI, clock; 0x49..0x4C slave selects.
// - Code 0x4D PLL feedback tap, 0x4E PLL reference tap.
// - Code 0x4F test-only and 0x52..0x7F reserved.
// - Code 0x50 drives constant low, 0x51 constant high.
// - Parallel-pins-as-flags bit 20 makes 16 address pins flags 0..15.
// - Four interrupt pins read as flags and raise interrupts.
// - Misc select fields are read/write, five bits, codes 0x0..0x1F.
// - Misc codes 0x0..0x13 select pin buffers 1..20.
// - Misc codes 0x14..0x16 select timers 0..2; 0x17, 0x18 reserved.
// - Misc 0x19 strobe; 0x1A..0x1D clock A, fs A, clock B, fs B.
// - Misc 0x1E constant zero, 0x1F constant one.
// - Misc route A bits 30/31 invert misc A inputs 4/5.
// - Misc B inputs 2..5 can be routed directly to pin buffers.
// - Misc routing feeds interrupt/timer inputs and pin-to-pin links.
// - Pin assignment select fields are seven bits wide.
module audio_signal_route_mux
  import asr_pkg::*;
#(
  parameter int NUM_PINS = 20,
  parameter int NUM_IRQ = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire asr_ahb_req_t ahbReq,
  output asr_ahb_rsp_t ahbRsp,
  input wire asr_src_t periphSrc,
  input wire logic [NUM_PINS-1:0] pinBufOut,
  input wire logic [15:0] parallelAddrOut,
  input wire logic [NUM_IRQ-1:0] irqPin_n,
  output logic [NUM_PINS-1:0] pinBufIn,
  output logic [ASR_NUM_MISC-1:0] miscAIn,
  output logic [ASR_NUM_MISC-1:0] miscBIn,
  output logic [15:0] parallelPinOut,
  output logic [NUM_IRQ-1:0] irqFlag,
  output logic [NUM_IRQ-1:0] irqRequest
);

  // The encodings cover exactly this many pins and interrupt lines
  generate
    if (NUM_PINS != ASR_NUM_PINS || NUM_IRQ != ASR_NUM_IRQ) begin : gBadParams
      $error("audio_signal_route_mux: NUM_PINS must be 20 and NUM_IRQ must be 4");
    end
  endgenerate

  asr_state_t cur_r;
  asr_state_t cur_nxt;

  // Pin assignment source decode
  function automatic logic pinDecode(input logic [6:0] code, input asr_src_t s, input logic [5:0] mb);
    logic r;
    logic [6:0] off;
    r = 1'b0;
    off = 7'h00;
    if (code <= PC_MISC_B_LAST) begin
      off = code - PC_MISC_B_FIRST;
      r = mb[off[1:0] + 3'd2];
    end else if (code >= PC_SER_CLK_FIRST && code <= PC_SER_CLK_LAST) begin
      off = code - PC_SER_CLK_BASE;
      r = s.serialPortClk[off[2:0]];
    end else if (code >= PC_SER_FS_FIRST && code <= PC_SER_FS_LAST) begin
      off = code - PC_SER_FS_FIRST;
      r = s.serialPortFs[off[2:0]];
    end else if (code >= PC_TIMER_FIRST && code <= PC_TIMER_LAST) begin
      off = code - PC_TIMER_FIRST;
      r = s.timerOut[off[1:0]];
    end else if (code == PC_FLAG10) begin
      r = s.gpFlagOut[10];
    end else if (code == PC_ACQ_STROBE) begin
      r = s.acquisitionPortStrobe;
    end else if (code >= PC_FLAG11_FIRST && code <= PC_FLAG11_LAST) begin
      off = code - PC_FLAG11_FIRST;
      r = s.gpFlagOut[off[3:0] + 4'd11];
    end else if (code == PC_FLAG15) begin
      r = s.gpFlagOut[15];
    end else if (code >= PC_RATE_CONV_FIRST && code <= PC_RATE_CONV_LAST) begin
      off = code - PC_RATE_CONV_FIRST;
      r = s.rateConverterData[off[1:0]];
    end else if (code >= PC_SPI_SS_FIRST && code <= PC_SPI_SS_LAST) begin
      off = code - PC_SPI_SS_FIRST;
      r = s.secondarySpiSlaveSelect[off[1:0]];
    end else begin
      case (code)
        PC_PREC_CLK_A: r = s.precisionClock[0];
        PC_PREC_CLK_B: r = s.precisionClock[1];
        PC_PREC_FS_A: r = s.precisionFrameSync[0];
        PC_PREC_FS_B: r = s.precisionFrameSync[1];
        PC_RX_DATA: r = s.audioReceiverData;
        PC_RX_FS: r = s.audioReceiverFs;
        PC_RX_CLK: r = s.audioReceiverClock;
        PC_RX_TDM_CLK: r = s.audioReceiverTdmClock;
        PC_TX_DATA: r = s.audioTransmitterData;
        PC_SPI_MISO: r = s.secondarySpiMiso;
        PC_SPI_MOSI: r = s.secondarySpiMosi;
        PC_SPI_CLK: r = s.secondarySpiClock;
        PC_PLL_FB: r = s.pllFeedbackTap;
        PC_PLL_REF: r = s.pllReferenceTap;
        PC_LOW: r = 1'b0;
        PC_HIGH: r = 1'b1;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // Miscellaneous source decode
  function automatic logic miscDecode(input logic [4:0] code, input asr_src_t s, input logic [19:0] pb);
    logic r;
    logic [4:0] off;
    r = 1'b0;
    off = 5'h00;
    if (code <= MC_PIN_LAST) begin
      r = pb[code];
    end else if (code >= MC_TIMER_FIRST && code <= MC_TIMER_LAST) begin
      off = code - MC_TIMER_FIRST;
      r = s.timerOut[off[1:0]];
    end else begin
      case (code)
        MC_ACQ_STROBE: r = s.acquisitionPortStrobe;
        MC_PREC_CLK_A: r = s.precisionClock[0];
        MC_PREC_FS_A: r = s.precisionFrameSync[0];
        MC_PREC_CLK_B: r = s.precisionClock[1];
        MC_PREC_FS_B: r = s.precisionFrameSync[1];
        MC_LOW: r = 1'b0;
        MC_HIGH: r = 1'b1;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] readReg(input logic [7:0] a, input asr_state_t st);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `ASR_OFF_PIN0: d = st.pinSel[0];
      `ASR_OFF_PIN1: d = st.pinSel[1];
      `ASR_OFF_PIN2: d = st.pinSel[2];
      `ASR_OFF_PIN3: d = st.pinSel[3];
      `ASR_OFF_PIN4: d = st.pinSel[4];
      `ASR_OFF_MISC_A: d = st.miscRouteA;
      `ASR_OFF_MISC_B: d = st.miscRouteB;
      `ASR_OFF_SYS_CONTROL: d = st.systemControl;
      `ASR_OFF_STATUS: begin
        d[ASR_NUM_PINS-1:0] = st.pinBufIn;
        d[`ASR_STATUS_IRQ_LSB +: ASR_NUM_IRQ] = st.irqFlag;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_comb begin
    logic addrPhase;
    logic [6:0] pinCode;
    logic [4:0] miscCode;
    logic routed;
    addrPhase = 1'b0;
    pinCode = 7'h00;
    miscCode = 5'h00;
    routed = 1'b0;
    cur_nxt = cur_r;

    // Data phase of a write: store the whole word
    if (cur_r.wrPend) begin
      case (cur_r.wrAddr)
        `ASR_OFF_PIN0: cur_nxt.pinSel[0] = ahbReq.hwdata;
        `ASR_OFF_PIN1: cur_nxt.pinSel[1] = ahbReq.hwdata;
        `ASR_OFF_PIN2: cur_nxt.pinSel[2] = ahbReq.hwdata;
        `ASR_OFF_PIN3: cur_nxt.pinSel[3] = ahbReq.hwdata;
        `ASR_OFF_PIN4: cur_nxt.pinSel[4] = ahbReq.hwdata;
        `ASR_OFF_MISC_A: cur_nxt.miscRouteA = ahbReq.hwdata;
        `ASR_OFF_MISC_B: cur_nxt.miscRouteB = ahbReq.hwdata;
        `ASR_OFF_SYS_CONTROL: cur_nxt.systemControl = ahbReq.hwdata;
        default: cur_nxt.systemControl = cur_r.systemControl;
      endcase
    end

    // Address phase; read data is taken from the updated copy so a read right after a write sees it
    addrPhase = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
    cur_nxt.wrPend = addrPhase && ahbReq.hwrite;
    cur_nxt.wrAddr = addrPhase ? ahbReq.haddr[7:0] : 8'h00;
    cur_nxt.rdData = 32'h0000_0000;
    if (addrPhase && !ahbReq.hwrite) begin
      cur_nxt.rdData = readReg(ahbReq.haddr[7:0], cur_nxt);
    end

    // Interrupt pins: a change counts once stages two and three agree
    cur_nxt.irqS1 = irqPin_n;
    cur_nxt.irqS2 = cur_r.irqS1;
    cur_nxt.irqS3 = cur_r.irqS2;
    for (int i = 0; i < ASR_NUM_IRQ; i++) begin
      if (cur_r.irqS2[i] == cur_r.irqS3[i]) begin
        cur_nxt.irqFlag[i] = ~cur_r.irqS3[i];
      end
    end

    // Pin buffer inputs, four seven-bit fields per register
    for (int p = 0; p < ASR_NUM_PINS; p++) begin
      pinCode = cur_r.pinSel[p / `ASR_PIN_FIELDS_PER_REG][(p % `ASR_PIN_FIELDS_PER_REG) * `ASR_PIN_FIELD_W +: 7];
      cur_nxt.pinBufIn[p] = pinDecode(pinCode, periphSrc, cur_r.miscBIn);
    end

    // Miscellaneous inputs drive interrupt, timer and pin-to-pin destinations
    for (int m = 0; m < ASR_NUM_MISC; m++) begin
      miscCode = cur_r.miscRouteA[m * `ASR_MISC_FIELD_W +: 5];
      routed = miscDecode(miscCode, periphSrc, pinBufOut);
      if (m == 4) begin
        routed = routed ^ cur_r.miscRouteA[`ASR_MISC_INV4_BIT];
      end
      if (m == 5) begin
        routed = routed ^ cur_r.miscRouteA[`ASR_MISC_INV5_BIT];
      end
      cur_nxt.miscAIn[m] = routed;
      miscCode = cur_r.miscRouteB[m * `ASR_MISC_FIELD_W +: 5];
      cur_nxt.miscBIn[m] = miscDecode(miscCode, periphSrc, pinBufOut);
    end

    // Address pins carry the flag outputs instead of the address when switched over
    if (cur_r.systemControl[`ASR_SYS_CONTROL_FLAGS_BIT]) begin
      cur_nxt.parallelPinOut = periphSrc.gpFlagOut;
    end else begin
      cur_nxt.parallelPinOut = parallelAddrOut;
    end

    if (reset) begin
      cur_nxt = '0;
      cur_nxt.pinSel = {ASR_NUM_PIN_REGS{`ASR_RST_PIN}};
      cur_nxt.miscRouteA = `ASR_RST_MISC;
      cur_nxt.miscRouteB = `ASR_RST_MISC;
      cur_nxt.systemControl = `ASR_RST_SYS_CONTROL;
      cur_nxt.irqS1 = '1;
      cur_nxt.irqS2 = '1;
      cur_nxt.irqS3 = '1;
    end
  end

  always_ff @(posedge clk) begin
    cur_r <= cur_nxt;
  end

  // Zero wait states and always OKAY, so one driver covers the whole response
  assign ahbRsp = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: cur_r.rdData};
  assign pinBufIn = cur_r.pinBufIn;
  assign miscAIn = cur_r.miscAIn;
  assign miscBIn = cur_r.miscBIn;
  assign parallelPinOut = cur_r.parallelPinOut;
  assign irqFlag = cur_r.irqFlag;
  // Level request; the interrupt controller owns edge detection and clearing
  assign irqRequest = cur_r.irqFlag;

endmodule // audio_signal_route_mux

// ---- asr_route_monitor.sv ----
`timescale 1ns/1ps
module asr_route_monitor
  import asr_pkg::*;
#(
  parameter int NUM_PINS = 20,
  parameter int NUM_IRQ = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire asr_ahb_req_t ahbReq,
  input wire asr_ahb_rsp_t ahbRsp,
  input wire asr_src_t periphSrc,
  input wire logic [15:0] parallelAddrOut,
  input wire logic [NUM_IRQ-1:0] irqPin_n,
  input wire logic [NUM_PINS-1:0] pinBufIn,
  input wire logic [ASR_NUM_MISC-1:0] miscAIn,
  input wire logic [15:0] parallelPinOut,
  input wire logic [NUM_IRQ-1:0] irqFlag,
  input wire logic [NUM_IRQ-1:0] irqRequest
);
  // Shadow of three selects, rebuilt from bus writes, since the checker sees no internals
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic [31:0] pin0_r;
  logic [31:0] miscA_r;
  logic [31:0] system_control_reg_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      pin0_r <= 32'h0A14_2850;
      miscA_r <= 32'h3DEF_7BDE;
      system_control_reg_r <= 32'h0000_0000;
    end else begin
      wrPend_r <= ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hwrite && ahbReq.hready;
      wrAddr_r <= ahbReq.haddr[7:0];
      if (wrPend_r && wrAddr_r == 8'h00) pin0_r <= ahbReq.hwdata;
      if (wrPend_r && wrAddr_r == 8'h14) miscA_r <= ahbReq.hwdata;
      if (wrPend_r && wrAddr_r == 8'h1C) system_control_reg_r <= ahbReq.hwdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_bus_okay: assert property (ahbRsp.hreadyout && !ahbRsp.hresp) else $error("bus answer not ready or not OKAY");
  a_read_idle: assert property (!(ahbReq.hsel && ahbReq.htrans[1] && !ahbReq.hwrite) |=> ahbRsp.hrdata == 32'h0)
    else $error("read data stands without a read");
  a_irq_raise: assert property ((irqPin_n[0] == 1'b0) [*5] |-> irqFlag[0]) else $error("low pin not flagged");
  a_irq_drop: assert property (irqPin_n[0] [*5] |-> !irqFlag[0]) else $error("high pin still flagged");
  a_irq_level: assert property (irqRequest == irqFlag) else $error("request differs from flag");
  a_pin_reserved: assert property ((pin0_r[6:0] inside {7'h31, 7'h32, 7'h33, 7'h4F, 7'h50} || pin0_r[6:0] >= 7'h52) [*2]
    |-> !pinBufIn[0]) else $error("reserved or low code not low");
  a_pin_high: assert property ((pin0_r[6:0] == 7'h51) [*2] |-> pinBufIn[0]) else $error("high code not high");
  a_pin_timer: assert property ((pin0_r[6:0] == 7'h2C) [*2] |-> pinBufIn[0] == $past(periphSrc.timerOut[0]))
    else $error("timer 0 not routed");
  a_misc_invert: assert property ((miscA_r[24:20] == 5'h1E && miscA_r[30]) [*2] |-> miscAIn[4])
    else $error("misc a4 not inverted");
  // Reset is kept out of the window: the output holds its reset value on the release edge
  a_flag_mode: assert property ((system_control_reg_r[20] && !reset) [*2] |-> parallelPinOut == $past(periphSrc.gpFlagOut))
    else $error("parallel pins not flags");
  a_addr_mode: assert property ((!system_control_reg_r[20] && !reset) [*2] |-> parallelPinOut == $past(parallelAddrOut))
    else $error("parallel pins not address");
  a_reset_clear: assert property (disable iff (1'b0) reset |=> pinBufIn == '0 && miscAIn == '0 && irqFlag == '0)
    else $error("outputs not cleared by reset");
  c_pin_high: cover property ((pin0_r[6:0] == 7'h51) [*2]);
  c_invert: cover property (miscA_r[30] && miscAIn[4]);
  c_flag_mode: cover property (system_control_reg_r[20] [*2]);
  c_irq: cover property (irqFlag[0]);
endmodule // asr_route_monitor

bind audio_signal_route_mux asr_route_monitor #(.NUM_PINS(NUM_PINS), .NUM_IRQ(NUM_IRQ)) u_monitor (
  .clk(clk), .reset(reset), .ahbReq(ahbReq), .ahbRsp(ahbRsp), .periphSrc(periphSrc),
  .parallelAddrOut(parallelAddrOut), .irqPin_n(irqPin_n), .pinBufIn(pinBufIn), .miscAIn(miscAIn),
  .parallelPinOut(parallelPinOut), .irqFlag(irqFlag), .irqRequest(irqRequest));

// ---- asr_far_model.sv ----
`timescale 1ns/1ps
module asr_far_model
  import asr_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic [3:0] irqLow,
  output asr_src_t periphSrc,
  output logic [19:0] pinBufOut,
  output logic [15:0] parallelAddrOut,
  output logic [3:0] irqPin_n
);
  logic [63:0] pat;
  // Two unrelated patterns and their inverses, so a wrong tap shows up in some mode
  assign pat = mode[0] ? 64'h9E37_79B9_7F4A_7C15 : 64'hC2B2_AE3D_27D4_EB4F;
  assign periphSrc = mode[1] ? ~pat[$bits(asr_src_t)-1:0] : pat[$bits(asr_src_t)-1:0];
  assign pinBufOut = pat[63:44] ^ {20{mode[1]}};
  assign parallelAddrOut = pat[31:16] ^ {16{mode[1]}};
  assign irqPin_n = ~irqLow;
endmodule // asr_far_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
  import asr_pkg::*;
;
  logic clk = 1'b0;
  logic reset;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0] mode;
  logic [3:0] irqLow;
  asr_ahb_req_t ahbReq;
  asr_ahb_rsp_t ahbRsp;
  asr_src_t srcBus;
  logic [19:0] pinBufOut;
  logic [15:0] parallelAddrOut;
  logic [3:0] irqPin_n;
  logic [19:0] pinBufIn;
  logic [5:0] miscAIn;
  logic [5:0] miscBIn;
  logic [15:0] parallelPinOut;
  logic [3:0] irqFlag;
  logic [3:0] irqRequest;
  int nMismatch = 0;
  int samplesChecked = 0;
  always #25 clk = ~clk;
  assign ahbReq = '{hsel, haddr, htrans, hwrite, 3'b010, hwdata, ahbRsp.hreadyout};
  asr_far_model far (.mode(mode), .irqLow(irqLow), .periphSrc(srcBus), .pinBufOut(pinBufOut),
    .parallelAddrOut(parallelAddrOut), .irqPin_n(irqPin_n));
  audio_signal_route_mux dut (.clk(clk), .reset(reset), .ahbReq(ahbReq), .ahbRsp(ahbRsp), .periphSrc(srcBus),
    .pinBufOut(pinBufOut), .parallelAddrOut(parallelAddrOut), .irqPin_n(irqPin_n), .pinBufIn(pinBufIn),
    .miscAIn(miscAIn), .miscBIn(miscBIn), .parallelPinOut(parallelPinOut), .irqFlag(irqFlag),
    .irqRequest(irqRequest));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (ahbRsp.hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (ahbRsp.hreadyout !== 1'b1);
    rd = ahbRsp.hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(n, x, e);
  endtask
  // Covers the routing delay of the misc B feed into the pin selects too
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic giveVerdict();
    if (nMismatch == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic expPin(input logic [6:0] c, input asr_src_t s);
    case (c) inside
      [7'h21:7'h25]: return s.serialPortClk[c - 7'h20];
      [7'h26:7'h2B]: return s.serialPortFs[c - 7'h26];
      [7'h2C:7'h2E]: return s.timerOut[c - 7'h2C];
      7'h2F: return s.gpFlagOut[10];
      7'h30: return s.acquisitionPortStrobe;
      [7'h34:7'h37]: return s.gpFlagOut[c - 7'h29];
      [7'h38:7'h39]: return s.precisionClock[c - 7'h38];
      [7'h3A:7'h3B]: return s.precisionFrameSync[c - 7'h3A];
      7'h3C: return s.gpFlagOut[15];
      [7'h3D:7'h40]: return s.rateConverterData[c - 7'h3D];
      7'h41: return s.audioReceiverData;
      7'h42: return s.audioReceiverFs;
      7'h43: return s.audioReceiverClock;
      7'h44: return s.audioReceiverTdmClock;
      7'h45: return s.audioTransmitterData;
      7'h46: return s.secondarySpiMiso;
      7'h47: return s.secondarySpiMosi;
      7'h48: return s.secondarySpiClock;
      [7'h49:7'h4C]: return s.secondarySpiSlaveSelect[c - 7'h49];
      7'h4D: return s.pllFeedbackTap;
      7'h4E: return s.pllReferenceTap;
      7'h51: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic expMisc(input logic [4:0] c, input asr_src_t s, input logic [19:0] pb);
    case (c) inside
      [5'h00:5'h13]: return pb[c];
      [5'h14:5'h16]: return s.timerOut[c - 5'h14];
      5'h19: return s.acquisitionPortStrobe;
      5'h1A: return s.precisionClock[0];
      5'h1B: return s.precisionFrameSync[0];
      5'h1C: return s.precisionClock[1];
      5'h1D: return s.precisionFrameSync[1];
      5'h1F: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    giveVerdict();
  end
  initial begin
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, mode, irqLow} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rdc("pin select reset", 8'(4 * i), 32'h0A14_2850);
    rdc("misc a reset", 8'h14, 32'h3DEF_7BDE);
    rdc("system control reset", 8'h1C, 32'h0000_0000);
    rdc("unmapped read", 8'h40, 32'h0000_0000);
    check("routed after reset", {pinBufIn, miscAIn, miscBIn}, 32'h0);
    wr(8'h04, 32'h7FFF_FFFF);
    rdc("pin select readback", 8'h04, 32'h7FFF_FFFF);
    wr(8'h04, 32'h0A14_2850);
    for (int c = 0; c < 128; c++) begin
      wr(8'h00, 32'h0A14_2800 | 32'(c));
      for (int m = 0; m < 4; m++) begin
        mode <= 2'(m);
        settle();
        check("pin 1 route", 32'(pinBufIn[0]), 32'(expPin(7'(c), srcBus)));
      end
    end
    wr(8'h10, 32'h0A34_2850);
    settle();
    check("pin 20 high", 32'(pinBufIn), 32'h0008_0000);
    wr(8'h10, 32'h0A14_2850);
    for (int c = 0; c < 32; c++) begin
      wr(8'h14, 32'h3DEF_7BC0 | 32'(c));
      wr(8'h18, 32'h01EF_7BDE | (32'(c) << 25));
      for (int m = 0; m < 4; m++) begin
        mode <= 2'(m);
        settle();
        check("misc a0 route", 32'(miscAIn[0]), 32'(expMisc(5'(c), srcBus, pinBufOut)));
        check("misc b5 route", 32'(miscBIn[5]), 32'(expMisc(5'(c), srcBus, pinBufOut)));
      end
    end
    rdc("misc b readback", 8'h18, 32'h3FEF_7BDE);
    wr(8'h14, 32'hFDEF_7BDE);
    settle();
    check("misc a both inverted", 32'(miscAIn), 32'h0000_0030);
    wr(8'h14, 32'h7DEF_7BDE);
    settle();
    check("misc a4 inverted", 32'(miscAIn), 32'h0000_0010);
    wr(8'h18, 32'h3DEF_7FDE);
    wr(8'h00, 32'h0A14_2800);
    settle();
    check("misc b2 to pin 1", 32'(pinBufIn[0]), 32'h1);
    wr(8'h00, 32'h0A14_2803);
    settle();
    check("misc b5 to pin 1", 32'(pinBufIn[0]), 32'h0);
    wr(8'h00, 32'h0A14_2850);
    wr(8'h1C, 32'h0010_0000);
    rdc("system control readback", 8'h1C, 32'h0010_0000);
    settle();
    check("parallel pins as flags", 32'(parallelPinOut), 32'(srcBus.gpFlagOut));
    wr(8'h1C, 32'h0000_0000);
    settle();
    check("parallel pins as address", 32'(parallelPinOut), 32'(parallelAddrOut));
    irqLow <= 4'b0101;
    repeat (6) @(posedge clk);
    check("interrupt flags", 32'({irqFlag, irqRequest}), 32'h55);
    rdc("status with flags", 8'h20, 32'h0050_0000);
    irqLow <= 4'b0000;
    repeat (6) @(posedge clk);
    check("interrupt flags clear", 32'({irqFlag, irqRequest}), 32'h0);
    giveVerdict();
  end
endmodule // testbench
